// ==== verilog/watchdog_pkg.sv ====
// constants for the watchdog / interval timer block
// assumes a byte-addressed peripheral bus with 32-bit data words
package watchdog_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, low 16 bits of the bus address)
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_CONTROL  = 16'h1100;
    localparam logic [15:0] ADDR_STATUS   = 16'h1104;
    localparam logic [15:0] ADDR_COUNTER  = 16'h1108;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int          CTL_IRQ_EN_POS   = 7;
    localparam int          CTL_MODE_POS     = 6;
    localparam int          CTL_ENABLE_POS   = 5;
    localparam int          CTL_RST_EN_POS   = 4;
    localparam int          CTL_RST_SEL_POS  = 3;
    localparam int          CTL_CLK_SEL_LSB  = 0;
    localparam int          CTL_CLK_SEL_W    = 3;
    localparam logic [7:0]  CTL_RESET        = 8'h00;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int          STS_WD_OVF_POS   = 0;
    localparam int          STS_IT_OVF_POS   = 1;
    localparam logic [1:0]  STS_RESET        = 2'h0;

    // ----------------------------------------------------------------
    // counter and prescaler
    // ----------------------------------------------------------------
    localparam logic [7:0]  CNT_RESET        = 8'h00;
    localparam logic [7:0]  CNT_MAX          = 8'hff;
    localparam int          PRE_W            = 13;
    localparam logic [12:0] PRE_RESET        = 13'h0000;

    // log2 of the divisor for each clock select code: 2,8,32,64,256,512,2048,8192
    localparam logic [3:0]  DIV_LOG2 [8]     = '{4'h1, 4'h3, 4'h5, 4'h6,
                                                 4'h8, 4'h9, 4'hb, 4'hd};

    localparam logic        MODE_INTERVAL    = 1'b0;
    localparam logic        MODE_WATCHDOG    = 1'b1;
    localparam logic        RST_POWER_ON     = 1'b0;
    localparam logic        RST_MANUAL       = 1'b1;

endpackage

// ==== verilog/watchdog_interval_timer.sv ====
// watchdog / interval timer with its peripheral bus register slave
// assumes one 125 MHz clock, synchronous active-high reset, apb-style access
//
// Notes on behaviour
// - watchdog overflow raises interrupt and reset, gated
// - reset enable allows chip reset on overflow
// - reset type picks power-on or manual output
// - interval mode interrupts on every overflow
// - interval overflow sets interval flag, requests interrupt
// - watchdog overflow sets watchdog flag, timeout out
// - reading status register clears its flags
// - eight divided clocks, three-bit select
// - control, status, counter at fixed offsets
// - select codes give divide 2 to 8192
// - eight-bit up-counter, wrap ff to 00 overflows
// - reset type zero power-on, one manual
// - interrupt enable one passes, zero blocks
`timescale 1ns/1ns
module watchdog_interval_timer (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             timer_irq_o,
    output logic             power_on_reset_out_o,
    output logic             manual_reset_out_o,
    output logic             timeout_signal_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  control;
        logic [1:0]  status;
        logic [7:0]  tick_counter;
        logic [12:0] prescaler;
        logic [31:0] rdata;
        logic        por_out;
        logic        mnr_out;
        logic        timeout;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // true in the last prescaler cycle of each period of the chosen divisor
    function automatic logic tick_of(input logic [2:0]  sel,
                                     input logic [12:0] pre);
        logic [12:0] mask;
        mask = 13'h0000;
        for (int i = 0; i < watchdog_pkg::PRE_W; i++)
        begin
            if (i < int'(watchdog_pkg::DIV_LOG2[sel]))
            begin
                mask[i] = 1'b1;
            end
        end
        tick_of = ((pre & mask) == mask);
    endfunction

    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic        setup_phase;
    logic        access_phase;
    logic        hit_ctl;
    logic        hit_sts;
    logic        hit_cnt;
    logic        mapped;
    logic        enabled;
    logic        wd_mode;
    logic        tick;
    logic        cnt_write;
    logic        overflow;
    logic        wd_ovf;
    logic        it_ovf;
    logic [1:0]  read_clear;

    always_comb
    begin
        setup_phase  = psel_i & ~penable_i;
        access_phase = psel_i & penable_i;
        hit_ctl      = addr_is(paddr_i, watchdog_pkg::ADDR_CONTROL);
        hit_sts      = addr_is(paddr_i, watchdog_pkg::ADDR_STATUS);
        hit_cnt      = addr_is(paddr_i, watchdog_pkg::ADDR_COUNTER);
        mapped       = hit_ctl | hit_sts | hit_cnt;
        enabled      = state_q.control[watchdog_pkg::CTL_ENABLE_POS];
        wd_mode      = (state_q.control[watchdog_pkg::CTL_MODE_POS]
                        == watchdog_pkg::MODE_WATCHDOG);
        tick         = tick_of(state_q.control[watchdog_pkg::CTL_CLK_SEL_LSB +:
                                               watchdog_pkg::CTL_CLK_SEL_W],
                               state_q.prescaler);
        cnt_write    = access_phase & pwrite_i & hit_cnt;
        overflow     = enabled & tick & ~cnt_write
                       & (state_q.tick_counter == watchdog_pkg::CNT_MAX);
        wd_ovf       = overflow & wd_mode;
        it_ovf       = overflow & ~wd_mode;
        // only bits already returned to software are cleared
        read_clear   = (access_phase & ~pwrite_i & hit_sts)
                       ? state_q.rdata[1:0] : 2'h0;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;

        state_d.prescaler = state_q.prescaler + 13'h0001;

        // counter: a write loads at once, otherwise count on the selected tick
        if (cnt_write)
        begin
            state_d.tick_counter = pwdata_i[7:0];
        end
        else if (enabled && tick)
        begin
            state_d.tick_counter = state_q.tick_counter + 8'h01;
        end

        if (access_phase && pwrite_i && hit_ctl)
        begin
            state_d.control = pwdata_i[7:0];
        end

        // flags: a new overflow wins over a read clear
        state_d.status = (state_q.status & ~read_clear)
                         | {it_ovf, wd_ovf};

        // reset request pulses toward the power manager
        state_d.por_out = wd_ovf & state_q.control[watchdog_pkg::CTL_RST_EN_POS]
                          & (state_q.control[watchdog_pkg::CTL_RST_SEL_POS]
                             == watchdog_pkg::RST_POWER_ON);
        state_d.mnr_out = wd_ovf & state_q.control[watchdog_pkg::CTL_RST_EN_POS]
                          & (state_q.control[watchdog_pkg::CTL_RST_SEL_POS]
                             == watchdog_pkg::RST_MANUAL);
        state_d.timeout = wd_ovf;

        // read data is captured in the setup phase
        if (setup_phase && !pwrite_i)
        begin
            state_d.rdata = 32'h0000_0000;
            if (hit_ctl)
            begin
                state_d.rdata[7:0] = state_q.control;
            end
            if (hit_sts)
            begin
                state_d.rdata[1:0] = state_q.status;
            end
            if (hit_cnt)
            begin
                state_d.rdata[7:0] = state_q.tick_counter;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q.control      <= watchdog_pkg::CTL_RESET;
            state_q.status       <= watchdog_pkg::STS_RESET;
            state_q.tick_counter <= watchdog_pkg::CNT_RESET;
            state_q.prescaler    <= watchdog_pkg::PRE_RESET;
            state_q.rdata        <= 32'h0000_0000;
            state_q.por_out      <= 1'b0;
            state_q.mnr_out      <= 1'b0;
            state_q.timeout      <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        prdata_o             = state_q.rdata;
        pready_o             = 1'b1;
        pslverr_o            = access_phase & ~mapped;
        // interrupt holds while a flag is pending and the enable is set
        timer_irq_o          = state_q.control[watchdog_pkg::CTL_IRQ_EN_POS]
                               & (|state_q.status);
        power_on_reset_out_o = state_q.por_out;
        manual_reset_out_o   = state_q.mnr_out;
        timeout_signal_o     = state_q.timeout;
    end

endmodule

// ==== tb/watchdog_props.sv ====
// port assertions for the watchdog block
// assumes bind onto watchdog_interval_timer, one clock, synchronous reset
`timescale 1ns/1ns
module watchdog_props (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        timer_irq_o,
    input wire logic        power_on_reset_out_o,
    input wire logic        manual_reset_out_o,
    input wire logic        timeout_signal_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire logic hit = paddr_i[15:4] == 12'h110 && paddr_i[3:0] inside {4'h0, 4'h4, 4'h8};
    sequence s_acc; psel_i && penable_i; endsequence
    property p_ready; pready_o; endproperty
    property p_err; s_acc |-> pslverr_o == !hit; endproperty
    property p_bad_rd; s_acc ##0 (!pwrite_i && !hit) |-> prdata_o == 32'h0; endproperty
    property p_upper; s_acc ##0 !pwrite_i |-> prdata_o[31:8] == 24'h0; endproperty
    property p_tmo; timeout_signal_o |=> !timeout_signal_o; endproperty
    property p_por; power_on_reset_out_o |-> timeout_signal_o && !manual_reset_out_o; endproperty
    property p_man; manual_reset_out_o |-> timeout_signal_o ##1 !manual_reset_out_o; endproperty
    property p_irq; timer_irq_o && !psel_i |=> timer_irq_o; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    a_err: assert property (p_err) else $error("bad error flag");
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read data");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_tmo: assert property (p_tmo) else $error("timeout too long");
    a_por: assert property (p_por) else $error("stray power-on reset");
    a_man: assert property (p_man) else $error("stray manual reset");
    a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule
bind watchdog_interval_timer watchdog_props u_watchdog_props (.*);

// ==== tb/power_manager_model.sv ====
// power manager stand-in: counts reset requests
// assumes one-cycle active-high request pulses
`timescale 1ns/1ns
module power_manager_model (
    input wire logic clk_i,
    input wire logic por_i,
    input wire logic man_i
);
    int por_cnt = 0;
    int man_cnt = 0;
    always @(posedge clk_i) por_cnt <= por_cnt + int'(por_i);
    always @(posedge clk_i) man_cnt <= man_cnt + int'(man_i);
endmodule

// ==== tb/test_watchdog_interval_timer.sv ====
// self-checking bench for the watchdog block
// assumes the power manager model and the bound checker
`timescale 1ns/1ns
module test_watchdog_interval_timer;
    localparam logic [15:0] CTL = 16'h1100, STS = 16'h1104, CNT = 16'h1108;
    logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
    logic        pready_o, pslverr_o, timer_irq_o, timeout_signal_o;
    logic        power_on_reset_out_o, manual_reset_out_o;
    logic [15:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, d;
    logic [7:0]  c, rc[3] = '{8'he0, 8'hf0, 8'hf8};
    int          error_cnt = 0, num_checks = 0, t, k;
    int          dv[8] = '{2, 8, 32, 64, 256, 512, 2048, 8192};
    watchdog_interval_timer u_watchdog_interval_timer (.*);
    power_manager_model u_power_manager_model (.clk_i(clk_i), .por_i(power_on_reset_out_o),
        .man_i(manual_reset_out_o));
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        error_cnt += int'(g !== x);
        if (g !== x) $display("ERROR %s expected %h seen %h", n, x, g);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reads compare against v; writes send v
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] v);
        @(negedge clk_i) {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {2'b10, w, a, v};
        @(negedge clk_i) penable_i = 1;
        @(posedge clk_i) {d, e} = {prdata_o, pslverr_o};
        @(negedge clk_i) {psel_i, penable_i} = 2'b00;
        if (!w) chk($sformatf("reg %h", a), v, d);
        chk("err", 32'(!(a inside {CTL, STS, CNT})), 32'(e));
    endtask
    task automatic wait_ev(input int lim);
        for (t = 0; (timer_irq_o || timeout_signal_o) !== 1'b1 && t <= lim; t++) @(negedge clk_i);
        chk("wait", 32'h1, 32'(t <= lim));
        if (t > lim) report_and_stop();
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) srst_i = 0;
        xfer(0, CTL, 32'h0);
        xfer(0, 16'h110c, 32'h0);
        xfer(1, CTL, 32'hffff_ff1f);
        xfer(1, STS, 32'h3);
        xfer(1, CNT, 32'h5a);
        repeat (40) @(negedge clk_i);
        xfer(0, CTL, 32'h1f);
        xfer(0, STS, 32'h0);
        xfer(0, CNT, 32'h5a);
        $display("test registers done");
        xfer(1, CNT, 32'hf0);
        xfer(1, CTL, 32'ha0);
        for (k = 0; k < 2; k++)
        begin
            wait_ev(600);
            xfer(0, STS, 32'h2);
            chk("irq", 32'h0, 32'(timer_irq_o));
        end
        $display("test interval done");
        for (k = 0; k < 11; k++)
        begin
            c = (k < 8) ? 8'h60 | 8'(k) : rc[k - 8];
            xfer(1, CTL, 32'h40);
            xfer(1, CNT, 32'hfe);
            xfer(1, CTL, {24'h0, c});
            wait_ev(20000);
            chk("ticks", 32'h1, 32'(t >= dv[c[2:0]] && t <= 2 * dv[c[2:0]] + 2));
            chk("irq", 32'(k > 7), 32'(timer_irq_o));
            xfer(0, STS, 32'h1);
            chk("por", 32'(k > 8), u_power_manager_model.por_cnt);
            chk("man", 32'(k > 9), u_power_manager_model.man_cnt);
        end
        $display("test watchdog done");
        xfer(1, CTL, 32'h40);
        xfer(1, CNT, 32'h0);
        xfer(1, CTL, 32'h60);
        for (k = 0; k < 4; k++)
        begin
            repeat (300) @(negedge clk_i);
            xfer(1, CNT, 32'h0);
        end
        xfer(0, STS, 32'h0);
        $display("test rewrite done");
        report_and_stop();
    end
endmodule
